// [pkg/timer16_cfg.svh]
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// Register offsets
`define TMR_CONTROL_REG_A          8'h00
`define TMR_CONTROL_REG_B          8'h01
`define TMR_COMPARATOR_CTRL_STATUS 8'h02
`define TMR_FLAGS                  8'h03
`define TMR_IRQ_ENABLE             8'h04
`define TMR_COUNT_LOWER_BYTE       8'h08
`define TMR_COUNT_UPPER_BYTE       8'h09
`define TMR_CAPTURE_LOWER_BYTE     8'h0a
`define TMR_CAPTURE_UPPER_BYTE     8'h0b
`define TMR_COMPARE_A_LOWER_BYTE   8'h0c

// Field positions
`define TMR_A_MODE_LSB      0
`define TMR_A_ACTION_C_LSB  2
`define TMR_A_ACTION_B_LSB  4
`define TMR_A_ACTION_A_LSB  6
`define TMR_B_SOURCE_LSB    0
`define TMR_B_MODE_LSB      3
`define TMR_B_EDGE_BIT      6
`define TMR_B_FILTER_BIT    7
`define TMR_CMP_SELECT_BIT  0
`define TMR_FLAG_OVERFLOW   0
`define TMR_FLAG_COMPARE_A  1
`define TMR_FLAG_CAPTURE    4

// Reset values and fixed counts
`define TMR_RESET_BYTE      8'h00
`define TMR_RESET_WORD      16'h0000
`define TMR_BOTTOM          16'h0000
`define TMR_MAX             16'hffff
`define TMR_TOP_8BIT        16'h00ff
`define TMR_TOP_9BIT        16'h01ff
`define TMR_TOP_10BIT       16'h03ff
`define TMR_FILTER_SAMPLES  4

`endif

// [pkg/timer16_pkg.sv]
package timer16_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } busReq_t;

    typedef logic [15:0] word_t;

    typedef enum logic [1:0] {
        CLS_NORMAL,
        CLS_CTC,
        CLS_FAST,
        CLS_DUAL
    } cntClass_t;

endpackage

// [hdl/timer16_capture_compare.sv]
// How it works
// R01 - The shared upper-byte latch holds its value across lower-byte writes, so reuse is allowed.
// R02 - A three-bit clock source field in control B picks the timer tick.
// R03 - Sixteen-bit counter steps up, down by one, or clears on each tick.
// R04 - Top and bottom indications are raised at sequence maximum and zero.
// R05 - Upper count byte uses latch; lower read fills latch, lower write loads all.
// R06 - Source field zero stops ticks; count stays readable and writable.
// R07 - A processor write to the count beats any clear or count step.
// R08 - Four-bit mode field across A and B sets sequence and overflow flag.
// R09 - Matching capture edge copies count to capture value and sets flag together.
// R10 - Capture flag requests interrupt when enabled; service or written one clears it.
// R11 - Capture lower read copies upper byte to latch; upper read returns latch.
// R12 - Capture value is writable only in modes using it as top; upper first.
// R13 - First instance may take capture trigger from comparator; software clears flag after.
// R14 - Noise filter output changes only after four equal consecutive samples.
// R15 - Filter enable bit in control B adds four system clock cycles latency.
// R16 - Capture events are blocked only in modes where capture value is top; the filter keeps sampling.
// R17 - Each new capture overwrites the capture value even if unread.
// R18 - Software may trigger a capture by driving the capture pin from its port.
// R19 - Comparators check count continuously; equality sets compare flag at next tick.
// R20 - Compare flag requests interrupt when enabled; service or written one clears it.
// R21 - Waveform output follows match, mode and action field, using top and bottom.
// R22 - Channel A compare value sets top in the modes that select it.
// R23 - Bottom is zero, max all ones; top fixed or from compare A or capture.
// R24 - A count write suppresses compare match at the following tick, even stopped.
// R25 - A configuration bit picks rising or falling capture edge.
`include "timer16_cfg.svh"

module timer16_capture_compare #(
    parameter int NUM_CH         = 3,
    parameter bit FIRST_INSTANCE = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire timer16_pkg::busReq_t   busReq,
    output logic [7:0]                  rdata,
    input  wire logic [3:0]             prescTick,
    input  wire logic                   extClkPin,
    input  wire logic                   captureInputPin,
    input  wire logic                   comparatorOutput,
    input  wire logic [4:0]             irqAck,
    output logic [4:0]                  irqReq,
    output logic [2:0]                  compareOut,
    output logic                        topHit,
    output logic                        bottomHit
);
    import timer16_pkg::*;

    localparam int FILT_W = `TMR_FILTER_SAMPLES - 1;

    if (NUM_CH != 3 || `TMR_FILTER_SAMPLES < 2)
    begin : g_check
        $error("timer16: unsupported channel count or filter length");
    end

    function automatic cntClass_t modeClass(input logic [3:0] m);
        unique case (m)
            4'h0, 4'h d:              modeClass = CLS_NORMAL;
            4'h4, 4'hc:               modeClass = CLS_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: modeClass = CLS_FAST;
            default:                  modeClass = CLS_DUAL;
        endcase
    endfunction

    function automatic logic capTopMode(input logic [3:0] m);
        capTopMode = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
    endfunction

    function automatic word_t topOf(input logic [3:0] m, input word_t cmpA,
                                    input word_t cap);
        unique case (m)
            4'h1, 4'h5:               topOf = `TMR_TOP_8BIT;
            4'h2, 4'h6:               topOf = `TMR_TOP_9BIT;
            4'h3, 4'h7:               topOf = `TMR_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf:   topOf = cmpA;
            4'h8, 4'ha, 4'hc, 4'he:   topOf = cap;
            default:                  topOf = `TMR_MAX;
        endcase
    endfunction

    function automatic logic [7:0] cmpAddr(input int ch, input logic upper);
        cmpAddr = 8'(`TMR_COMPARE_A_LOWER_BYTE + 2 * ch) | {7'h00, upper};
    endfunction

    logic [7:0]  ctrlA_r;
    logic [7:0]  ctrlB_r;
    logic        cmpSelect_r;
    logic [4:0]  irqEn_r;
    logic [4:0]  flags_r;
    logic [4:0]  flagSet;
    logic [4:0]  flagClr;
    logic [7:0]  temp_r;
    word_t       count_r;
    logic        countDown_r;
    word_t       capture_r;
    word_t       compare_r [3];
    logic [2:0]  oc_r;
    logic        blockNext_r;
    logic [7:0]  rdata_r;
    logic [2:0]  pinSync1_r;
    logic [2:0]  pinSync2_r;
    logic        extPrev_r;
    logic [FILT_W-1:0] filt_r;
    logic        filtOut_r;
    logic        edgePrev_r;

    logic [3:0]  mode;
    logic [2:0]  srcSel;
    cntClass_t   cls;
    word_t       top;
    logic        tick;
    logic        countWrite;
    logic        captureWrite;
    logic [2:0]  match;
    logic [2:0]  matchHit;
    logic        trigSrc;
    logic        edgeIn;
    logic        captureEvent;
    logic        overflowHit;
    logic [7:0]  readVal;
    logic [1:0]  action [3];

    assign mode   = {ctrlB_r[`TMR_B_MODE_LSB +: 2], ctrlA_r[`TMR_A_MODE_LSB +: 2]}; // R08
    assign srcSel = ctrlB_r[`TMR_B_SOURCE_LSB +: 3];
    assign cls    = modeClass(mode);
    assign top    = topOf(mode, compare_r[0], capture_r); // R22 R23
    assign action[0] = ctrlA_r[`TMR_A_ACTION_A_LSB +: 2];
    assign action[1] = ctrlA_r[`TMR_A_ACTION_B_LSB +: 2];
    assign action[2] = ctrlA_r[`TMR_A_ACTION_C_LSB +: 2];

    assign countWrite   = busReq.wr && busReq.addr == `TMR_COUNT_LOWER_BYTE;
    assign captureWrite = busReq.wr && busReq.addr == `TMR_CAPTURE_LOWER_BYTE
                          && capTopMode(mode); // R12

    // Control registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrlA_r     <= `TMR_RESET_BYTE;
            ctrlB_r     <= `TMR_RESET_BYTE;
            cmpSelect_r <= 1'b0;
            irqEn_r     <= 5'h00;
        end
        else if (busReq.wr)
        begin
            if (busReq.addr == `TMR_CONTROL_REG_A)
                ctrlA_r <= busReq.wdata;
            if (busReq.addr == `TMR_CONTROL_REG_B)
                ctrlB_r <= busReq.wdata;
            if (busReq.addr == `TMR_COMPARATOR_CTRL_STATUS)
                cmpSelect_r <= FIRST_INSTANCE && busReq.wdata[`TMR_CMP_SELECT_BIT]; // R13
            if (busReq.addr == `TMR_IRQ_ENABLE)
                irqEn_r <= busReq.wdata[4:0];
        end
    end

    // Shared upper-byte latch; untouched by lower writes so it can be reused
    always_ff @(posedge mclk)
    begin
        if (srst)
            temp_r <= `TMR_RESET_BYTE;
        else if (busReq.wr && (busReq.addr == `TMR_COUNT_UPPER_BYTE
                 || busReq.addr == `TMR_CAPTURE_UPPER_BYTE
                 || busReq.addr == cmpAddr(0, 1'b1)
                 || busReq.addr == cmpAddr(1, 1'b1)
                 || busReq.addr == cmpAddr(2, 1'b1)))
            temp_r <= busReq.wdata; // R01 R05
        else if (busReq.rd && busReq.addr == `TMR_COUNT_LOWER_BYTE)
            temp_r <= count_r[15:8]; // R05
        else if (busReq.rd && busReq.addr == `TMR_CAPTURE_LOWER_BYTE)
            temp_r <= capture_r[15:8]; // R11
    end

    // Tick selection
    always_comb
    begin
        case (srcSel)
            3'h0:    tick = 1'b0; // R06
            3'h1:    tick = 1'b1;
            3'h2:    tick = prescTick[0];
            3'h3:    tick = prescTick[1];
            3'h4:    tick = prescTick[2];
            3'h5:    tick = prescTick[3];
            3'h6:    tick = extPrev_r & ~pinSync2_r[0];
            default: tick = pinSync2_r[0] & ~extPrev_r;
        endcase
    end // R02

    // Pins arrive asynchronously
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pinSync1_r <= 3'h0;
            pinSync2_r <= 3'h0;
            extPrev_r  <= 1'b0;
        end
        else
        begin
            pinSync1_r <= {comparatorOutput, captureInputPin, extClkPin};
            pinSync2_r <= pinSync1_r;
            extPrev_r  <= pinSync2_r[0];
        end
    end

    // Counter
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            count_r     <= `TMR_RESET_WORD;
            countDown_r <= 1'b0;
        end
        else if (countWrite)
            count_r <= {temp_r, busReq.wdata}; // R05 R06 R07
        else if (tick)
        begin
            if (cls == CLS_DUAL)
            begin
                if (!countDown_r && count_r >= top)
                begin
                    countDown_r <= 1'b1;
                    count_r     <= count_r - 16'h0001;
                end
                else if (countDown_r && count_r == `TMR_BOTTOM)
                begin
                    countDown_r <= 1'b0;
                    count_r     <= count_r + 16'h0001;
                end
                else if (countDown_r)
                    count_r <= count_r - 16'h0001;
                else
                    count_r <= count_r + 16'h0001; // R03
            end
            else
            begin
                countDown_r <= 1'b0;
                // A count past a variable top runs on to max and wraps
                if (count_r == top)
                    count_r <= `TMR_BOTTOM;
                else
                    count_r <= count_r + 16'h0001; // R03
            end
        end
    end

    assign topHit    = count_r == top; // R04
    assign bottomHit = count_r == `TMR_BOTTOM; // R04

    always_comb
    begin
        unique case (cls)
            CLS_FAST: overflowHit = count_r == top;
            CLS_DUAL: overflowHit = countDown_r && count_r == `TMR_BOTTOM;
            default:  overflowHit = count_r == `TMR_MAX;
        endcase
    end // R08

    // Compare registers, written directly
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            for (int i = 0; i < 3; i++)
                compare_r[i] <= `TMR_RESET_WORD;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                if (busReq.wr && busReq.addr == cmpAddr(i, 1'b0))
                    compare_r[i] <= {temp_r, busReq.wdata};
        end
    end

    // Write blocks the match at the next tick, even with the timer stopped
    always_ff @(posedge mclk)
    begin
        if (srst)
            blockNext_r <= 1'b0;
        else if (countWrite)
            blockNext_r <= 1'b1; // R24
        else if (tick)
            blockNext_r <= 1'b0;
    end

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            match[i]    = count_r == compare_r[i]; // R19
            matchHit[i] = match[i] && tick && !blockNext_r && !countWrite; // R19 R24
        end
    end

    // Waveform outputs
    always_ff @(posedge mclk)
    begin
        if (srst)
            oc_r <= 3'h0;
        else if (tick && !countWrite)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (cls == CLS_FAST && topHit && action[i][1])
                    oc_r[i] <= ~action[i][0]; // R21
                if (matchHit[i])
                begin
                    unique case (cls)
                        CLS_FAST:
                            if (action[i][1])
                                oc_r[i] <= action[i][0];
                        CLS_DUAL:
                            if (action[i][1])
                                oc_r[i] <= action[i][0] ^ countDown_r;
                        default:
                            if (action[i] == 2'h1)
                                oc_r[i] <= ~oc_r[i];
                            else if (action[i][1])
                                oc_r[i] <= action[i][0];
                    endcase // R21
                end
            end
        end
    end

    assign compareOut = oc_r;

    // Capture path; pin may be driven by software through its port
    assign trigSrc = cmpSelect_r ? pinSync2_r[2] : pinSync2_r[1]; // R13 R18

    // Three stored samples plus the current one give four equal samples
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            filt_r     <= '0;
            filtOut_r  <= 1'b0;
            edgePrev_r <= 1'b0;
        end
        else
        begin
            filt_r <= {filt_r[FILT_W-2:0], trigSrc};
            if (&{filt_r, trigSrc})
                filtOut_r <= 1'b1; // R14
            else if (~|{filt_r, trigSrc})
                filtOut_r <= 1'b0; // R14
            edgePrev_r <= edgeIn;
        end
    end

    assign edgeIn = ctrlB_r[`TMR_B_FILTER_BIT] ? filtOut_r : trigSrc; // R15
    assign captureEvent = !capTopMode(mode) && (ctrlB_r[`TMR_B_EDGE_BIT] // R16
                          ? (edgeIn && !edgePrev_r) : (!edgeIn && edgePrev_r)); // R25

    always_ff @(posedge mclk)
    begin
        if (srst)
            capture_r <= `TMR_RESET_WORD;
        else if (captureEvent)
            capture_r <= count_r; // R09 R17
        else if (captureWrite)
            capture_r <= {temp_r, busReq.wdata}; // R12
    end

    // Flags: a set in the same cycle as a clear wins
    always_comb
    begin
        flagSet = 5'h00;
        flagSet[`TMR_FLAG_OVERFLOW] = tick && !countWrite && overflowHit; // R08
        for (int i = 0; i < 3; i++)
            flagSet[`TMR_FLAG_COMPARE_A + i] = matchHit[i]; // R19
        flagSet[`TMR_FLAG_CAPTURE] = captureEvent; // R09
        flagClr = irqAck;
        if (busReq.wr && busReq.addr == `TMR_FLAGS)
            flagClr = flagClr | busReq.wdata[4:0]; // R10 R20
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            flags_r <= 5'h00;
        else
            flags_r <= (flags_r & ~flagClr) | flagSet;
    end

    assign irqReq = flags_r & irqEn_r; // R10 R20

    // Register read, answered in the next cycle only
    always_comb
    begin
        readVal = 8'h00;
        unique case (busReq.addr)
            `TMR_CONTROL_REG_A:          readVal = ctrlA_r;
            `TMR_CONTROL_REG_B:          readVal = ctrlB_r;
            `TMR_COMPARATOR_CTRL_STATUS: readVal = {7'h00, cmpSelect_r};
            `TMR_FLAGS:                  readVal = {3'h0, flags_r};
            `TMR_IRQ_ENABLE:             readVal = {3'h0, irqEn_r};
            `TMR_COUNT_LOWER_BYTE:       readVal = count_r[7:0];
            `TMR_CAPTURE_LOWER_BYTE:     readVal = capture_r[7:0];
            `TMR_COUNT_UPPER_BYTE,
            `TMR_CAPTURE_UPPER_BYTE:     readVal = temp_r; // R05 R11
            default:
                for (int i = 0; i < 3; i++)
                begin
                    if (busReq.addr == cmpAddr(i, 1'b0))
                        readVal = compare_r[i][7:0];
                    if (busReq.addr == cmpAddr(i, 1'b1))
                        readVal = compare_r[i][15:8];
                end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            rdata_r <= 8'h00;
        else
            rdata_r <= busReq.rd ? readVal : 8'h00;
    end

    assign rdata = rdata_r;

endmodule

// [test/timer16_checker.sv]
module timer16_checker (
    input wire logic                 mclk,
    input wire logic                 srst,
    input wire timer16_pkg::busReq_t busReq,
    input wire logic [7:0]           rdata,
    input wire logic                 captureInputPin,
    input wire logic                 comparatorOutput,
    input wire logic [4:0]           irqAck,
    input wire logic [4:0]           irqReq,
    input wire logic                 topHit,
    input wire logic                 bottomHit
);
    timeunit 1ns;
    timeprecision 1ps;
    import timer16_pkg::*;
    logic [7:0] latchVal_r;
    logic       latchKnown_r;
    logic [1:0] pinPrev_r;
    logic [3:0] pinAge_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Latch is only predictable after an upper write with no lower read since
    always_ff @(posedge mclk)
    begin
        if (srst)
            latchKnown_r <= 1'b0;
        else if (busReq.wr && busReq.addr[0] && busReq.addr inside {[8'h09:8'h11]})
        begin
            latchKnown_r <= 1'b1;
            latchVal_r   <= busReq.wdata;
        end
        else if (busReq.rd && busReq.addr inside {8'h08, 8'h0a})
            latchKnown_r <= 1'b0;
    end
    // Cycles since a capture source moved, saturating
    always_ff @(posedge mclk)
    begin
        pinPrev_r <= {captureInputPin, comparatorOutput};
        if (srst)
            pinAge_r <= 4'hf;
        else if (pinPrev_r != {captureInputPin, comparatorOutput})
            pinAge_r <= 4'h0;
        else if (pinAge_r != 4'hf)
            pinAge_r <= pinAge_r + 4'h1;
    end
    chk_rdata_idle: assert property (!$past(busReq.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_unmapped_read: assert property (busReq.rd && busReq.addr == 8'h3f |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    chk_latch_read: assert property (busReq.rd && busReq.addr == 8'h09 && latchKnown_r
        |=> rdata == latchVal_r)
        else $error("upper count read did not return the shared latch");
    chk_reset_hits: assert property ($fell(srst) |-> bottomHit && !topHit)
        else $error("bottom or top indication wrong after reset");
    chk_ovf_fall: assert property ($fell(irqReq[0]) |-> $past(irqAck[0]) || $past(busReq.wr))
        else $error("overflow request dropped without a clear");
    chk_cmp_fall: assert property ($fell(irqReq[1]) |-> $past(irqAck[1]) || $past(busReq.wr))
        else $error("compare request dropped without a clear");
    chk_cap_fall: assert property ($fell(irqReq[4]) |-> $past(irqAck[4]) || $past(busReq.wr))
        else $error("capture request dropped without a clear");
    chk_cap_cause: assert property ($rose(irqReq[4]) |-> pinAge_r < 4'd12 || $past(busReq.wr))
        else $error("capture request without a recent input change");
    cover property ($rose(irqReq[4]));
    cover property ($rose(irqReq[1]));
    cover property ($rose(irqReq[0]));
endmodule

bind timer16_capture_compare timer16_checker timer16_checker_inst (
    .mclk             (mclk),
    .srst             (srst),
    .busReq           (busReq),
    .rdata            (rdata),
    .captureInputPin  (captureInputPin),
    .comparatorOutput (comparatorOutput),
    .irqAck           (irqAck),
    .irqReq           (irqReq),
    .topHit           (topHit),
    .bottomHit        (bottomHit)
);

// [test/cpu_port.sv]
module cpu_port (
    input  wire logic                 mclk,
    output timer16_pkg::busReq_t      busReq,
    input  wire logic [7:0]           rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import timer16_pkg::*;
    busReq_t    reqQ[$];
    logic [7:0] dataQ[$];
    logic       rdPend;
    initial
    begin
        busReq = '0;
        rdPend = 1'b0;
    end
    // One strobe per edge; read data stands only in the cycle after the read
    always @(posedge mclk)
    begin
        if (rdPend)
            dataQ.push_back(rdata);
        rdPend = busReq.rd;
        busReq <= (reqQ.size() > 0) ? reqQ.pop_front() : '0;
    end
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reqQ.push_back('{addr, data, 1'b1, 1'b0});
        wait (reqQ.size() == 0);
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        reqQ.push_back('{addr, 8'h00, 1'b0, 1'b1});
        wait (dataQ.size() > 0);
        data = dataQ.pop_front();
    endtask
    task automatic wr16(input logic [7:0] lowAddr, input logic [15:0] val);
        wr(lowAddr + 8'h01, val[15:8]);
        wr(lowAddr, val[7:0]);
    endtask
    task automatic rd16(input logic [7:0] lowAddr, output logic [15:0] val);
        rd(lowAddr, val[7:0]);
        rd(lowAddr + 8'h01, val[15:8]);
    endtask
endmodule

// [test/timer16_capture_compare_bench.sv]
module timer16_capture_compare_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer16_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    busReq_t     busReq;
    logic [7:0]  rdata;
    logic [3:0]  prescTick = 4'h0;
    logic        captureInputPin = 1'b0;
    logic        comparatorOutput = 1'b0;
    logic [7:0]  resetRegs [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h0a};
    logic [4:0]  irqAck = 5'h00;
    logic [4:0]  irqReq;
    logic [2:0]  compareOut;
    logic        topHit;
    logic        bottomHit;
    int          nMismatch = 0;
    int          nTests = 0;
    int          seed = 32'hf5520867;
    logic [15:0] cnt;
    logic [15:0] v;
    logic [7:0]  b;
    int          k;
    always #4 mclk = ~mclk;
    timer16_capture_compare timer16_capture_compare_inst (
        .mclk             (mclk),
        .srst             (srst),
        .busReq           (busReq),
        .rdata            (rdata),
        .prescTick        (prescTick),
        .extClkPin        (1'b0),
        .captureInputPin  (captureInputPin),
        .comparatorOutput (comparatorOutput),
        .irqAck           (irqAck),
        .irqReq           (irqReq),
        .compareOut       (compareOut),
        .topHit           (topHit),
        .bottomHit        (bottomHit)
    );
    cpu_port cpu_port_inst (
        .mclk   (mclk),
        .busReq (busReq),
        .rdata  (rdata)
    );
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic checkReg(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("Error at %0t: register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkPin(input logic got, input logic exp);
        nTests++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("Error at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        cpu_port_inst.rd(addr, b);
        checkReg({8'h00, b}, {8'h00, exp});
    endtask
    // Ticks come only from the prescaler lines, so counts are exact
    task automatic tick(input int n, input logic [3:0] which);
        repeat (n)
        begin
            @(posedge mclk);
            prescTick <= which;
            @(posedge mclk);
            prescTick <= 4'h0;
        end
        #1;
    endtask
    task automatic pin(input logic val, input int hold);
        @(posedge mclk);
        captureInputPin <= val;
        repeat (hold) @(posedge mclk);
    endtask
    task automatic ack(input logic [4:0] mask);
        @(posedge mclk);
        irqAck <= mask;
        @(posedge mclk);
        irqAck <= 5'h00;
        #1;
    endtask
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        nMismatch++;
        print_verdict();
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        foreach (resetRegs[i])
            rdChk(resetRegs[i], 8'h00);
        checkPin(bottomHit, 1'b1);
        checkPin(topHit, 1'b0);
        rdChk(8'h3f, 8'h00);
        cnt = 16'($random(seed));
        cpu_port_inst.wr16(8'h08, cnt);
        cpu_port_inst.rd16(8'h08, v);
        checkReg(v, cnt);
        repeat (20) @(posedge mclk);
        cpu_port_inst.rd16(8'h08, v);
        checkReg(v, cnt);
        b = 8'($random(seed));
        k = b;
        cpu_port_inst.wr(8'h0d, cnt[15:8]);
        rdChk(8'h09, cnt[15:8]);
        cpu_port_inst.wr(8'h0c, 8'(k));
        cpu_port_inst.wr(8'h08, ~8'(k));
        cpu_port_inst.rd16(8'h0c, v);
        checkReg(v, {cnt[15:8], 8'(k)});
        cpu_port_inst.rd16(8'h08, v);
        checkReg(v, {cnt[15:8], ~8'(k)});
        cnt = v;
        cpu_port_inst.wr(8'h01, 8'h02);
        k = 1 + ($unsigned($random(seed)) % 20);
        tick(k, 4'h1);
        tick(3, 4'h2);
        cpu_port_inst.rd16(8'h08, v);
        checkReg(v, cnt + 16'(k));
        cpu_port_inst.wr(8'h03, 8'h1f);
        cpu_port_inst.wr(8'h04, 8'h03);
        cpu_port_inst.wr(8'h00, 8'h40);
        cnt = {1'b0, 15'($random(seed))};
        cpu_port_inst.wr16(8'h0c, cnt);
        cpu_port_inst.wr16(8'h08, cnt);
        tick(1, 4'h1);
        rdChk(8'h03, 8'h00);
        cpu_port_inst.wr16(8'h08, cnt - 16'h0001);
        tick(2, 4'h1);
        rdChk(8'h03, 8'h02);
        checkPin(compareOut[0], 1'b1);
        checkPin(irqReq[1], 1'b1);
        ack(5'h02);
        checkPin(irqReq[1], 1'b0);
        cpu_port_inst.wr16(8'h08, 16'hffff);
        tick(1, 4'h1);
        checkPin(bottomHit, 1'b1);
        checkPin(irqReq[0], 1'b1);
        cpu_port_inst.wr(8'h03, 8'h01);
        rdChk(8'h03, 8'h00);
        cpu_port_inst.wr(8'h01, 8'h40);
        cpu_port_inst.wr16(8'h08, 16'($random(seed)));
        pin(1'b1, 12);
        rdChk(8'h03, 8'h10);
        checkPin(irqReq[4], 1'b0);
        cpu_port_inst.wr(8'h04, 8'h10);
        #1 checkPin(irqReq[4], 1'b1);
        ack(5'h10);
        checkPin(irqReq[4], 1'b0);
        cnt = 16'($random(seed));
        cpu_port_inst.wr16(8'h08, cnt);
        cpu_port_inst.wr(8'h01, 8'h00);
        pin(1'b0, 12);
        cpu_port_inst.rd16(8'h0a, v);
        checkReg(v, cnt);
        cpu_port_inst.wr(8'h03, 8'h10);
        pin(1'b1, 12);
        rdChk(8'h03, 8'h00);
        cpu_port_inst.wr(8'h01, 8'h80);
        pin(1'b0, 1);
        pin(1'b1, 12);
        rdChk(8'h03, 8'h00);
        pin(1'b0, 16);
        rdChk(8'h03, 8'h10);
        // Comparator as capture source; flag cleared after the switch
        cpu_port_inst.wr(8'h02, 8'h01);
        cpu_port_inst.wr(8'h03, 8'h10);
        @(posedge mclk);
        comparatorOutput <= 1'b1;
        repeat (12) @(posedge mclk);
        comparatorOutput <= 1'b0;
        repeat (16) @(posedge mclk);
        rdChk(8'h03, 8'h10);
        cpu_port_inst.wr(8'h02, 8'h00);
        cpu_port_inst.wr16(8'h0a, ~cnt);
        cpu_port_inst.rd16(8'h0a, v);
        checkReg(v, cnt);
        cpu_port_inst.wr(8'h01, 8'h58);
        cpu_port_inst.wr16(8'h0a, ~cnt);
        cpu_port_inst.rd16(8'h0a, v);
        checkReg(v, ~cnt);
        cpu_port_inst.wr(8'h03, 8'h10);
        pin(1'b1, 12);
        rdChk(8'h03, 8'h00);
        srst <= 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rdChk(8'h01, 8'h00);
        print_verdict();
    end
endmodule
